// ### rtl/cst_conv_ctrl.sv
// converter host-port timing: start alignment, busy, read and write strobes
`timescale 1ns/1ns
`default_nettype none
module cst_conv_ctrl
  import cst_pkg::*;
(
  // system clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // host port pins
  input wire logic conversion_start_n_i,
  input wire logic conv_clk_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  // parallel data bus, split into in, out and output enable (low = driving)
  input wire logic [DATA_W-1:0] data_in_i,
  output logic [DATA_W-1:0] data_out_o,
  output logic data_oe_n_o,
  // converter core side
  input wire logic [DATA_W-1:0] sample_result_i,
  output logic busy_o,
  output logic hold_o,
  output logic result_valid_o,
  output logic [DATA_W-1:0] write_word_o,
  output logic write_strobe_o,
  output logic [CNT_W-1:0] edge_count_o
);

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pin synchronisers reset high: the strobes idle high there, and a clock pin
  // that idles low reads as a fall after reset, never as a false rise
  cst_strobe_t pins_raw;
  cst_strobe_t pins;
  cst_strobe_t pins_q; // previous synchronised sample for edge detection

  assign pins_raw = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                      start_n: conversion_start_n_i, conv_clk: conv_clk_i};

  cst_sync #(.W($bits(cst_strobe_t))) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(pins_raw),
    .rst_val_i('1),
    .q_o(pins)
  );

  // data bus is sampled twice as well so the write capture sees a settled word
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_meta <= DATA_RESET;
      data_sync <= DATA_RESET;
    end else begin
      data_meta <= data_in_i;
      data_sync <= data_meta;
    end
  end

  // edge detection on synchronised copies only
  logic start_fall;
  logic clk_rise;
  logic rd_fall;
  logic wr_rise;
  logic cs_active;

  // a read or write strobe only counts while chip select is low
  function automatic logic gated(input logic ev, input logic cs_n);
    gated = ev & ~cs_n;
  endfunction : gated

  assign start_fall = pins_q.start_n & ~pins.start_n;
  assign clk_rise = ~pins_q.conv_clk & pins.conv_clk;
  assign cs_active = ~pins.cs_n;
  assign rd_fall = gated(pins_q.rd_n & ~pins.rd_n, pins.cs_n);
  assign wr_rise = gated(~pins_q.wr_n & pins.wr_n, pins_q.cs_n);

  // sequencer state
  cst_state_t state;
  cst_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;

  // next-state logic for the conversion sequencer
  always_comb begin
    next_state = state;
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    case (state)
      CST_SAMPLE: begin
        // the start fall holds the inputs whatever the clock is doing
        if (start_fall) begin
          next_state = CST_HOLD;
          next_busy = 1'b1;
          next_count = '0;
          // a clock rise in the very cycle of the fall counts as the start edge:
          // the start then came a little ahead of the sampled rise
          if (clk_rise) begin
            next_state = CST_CONVERT;
            next_count = 4'h1;
          end
        end
      end
      CST_HOLD: begin
        // a start that arrived after an edge waits for the following one
        if (clk_rise) begin
          next_state = CST_CONVERT;
          next_count = 4'h1;
        end
      end
      CST_CONVERT: begin
        if (clk_rise) begin
          next_count = count + 4'h1;
          if (count + 4'h1 == CONV_LAST) begin
            next_state = CST_SAMPLE;
            next_busy = 1'b0;
            next_done = 1'b1;
          end
        end
      end
      default: begin
        next_state = CST_SAMPLE;
        next_busy = 1'b0;
        next_count = '0;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= CST_SAMPLE;
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      pins_q <= '1;
    end else begin
      state <= next_state;
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
      pins_q <= pins;
    end
  end

  // output data and write capture state
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic [DATA_W-1:0] wword;
  logic [DATA_W-1:0] next_wword;
  logic wstb;
  logic next_wstb;
  logic rd_act;
  logic next_rd_act;

  // result latched at conversion end; read strobe fall drives the bus
  always_comb begin
    next_result = result;
    next_wword = wword;
    next_wstb = 1'b0;
    next_rd_act = rd_act;
    if (done) begin
      next_result = sample_result_i;
    end
    if (rd_fall) begin
      next_rd_act = 1'b1;
    end else if (pins.rd_n || !cs_active) begin
      next_rd_act = 1'b0;
    end
    // capture the word on the write strobe rise; the synchronised data lags
    // the strobe by the same two cycles, so the captured word is consistent
    if (wr_rise) begin
      next_wword = data_sync;
      next_wstb = 1'b1;
    end
  end

  // register data path
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result <= DATA_RESET;
      wword <= DATA_RESET;
      wstb <= 1'b0;
      rd_act <= 1'b0;
    end else begin
      result <= next_result;
      wword <= next_wword;
      wstb <= next_wstb;
      rd_act <= next_rd_act;
    end
  end

  // outputs: bus released whenever chip select is high
  assign data_out_o = result;
  assign data_oe_n_o = ~(rd_act & cs_active);
  assign busy_o = busy;
  assign hold_o = (state != CST_SAMPLE);
  assign result_valid_o = done;
  assign write_word_o = wword;
  assign write_strobe_o = wstb;
  assign edge_count_o = count;

endmodule : cst_conv_ctrl
`default_nettype wire

// ### rtl/cst_pkg.sv
// package: constants, states and carriers for the conversion start/busy block
package cst_pkg;

  // system clock rate and period
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // conversion clock edge timing window (ns) around a rising edge
  localparam int START_SETUP_NS = 10;
  localparam int START_HOLD_NS = 5;
  // setup margin in system cycles, rounded up, never below one
  localparam int START_SETUP_CYC_RAW = (START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_SETUP_CYC = (START_SETUP_CYC_RAW < 1) ? 1 : START_SETUP_CYC_RAW;

  // data width; conversion length in conversion clock rising edges, and its counter
  localparam int DATA_W = 12;
  localparam int CONV_EDGES = 14;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CONV_LAST = 4'hE;

  // reset value of the output data word
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;

  // conversion sequencer states
  typedef enum logic [1:0] {
    CST_SAMPLE,
    CST_HOLD,
    CST_CONVERT
  } cst_state_t;

  // host port strobes travelling together
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic start_n;
    logic conv_clk;
  } cst_strobe_t;

endpackage : cst_pkg

// ### rtl/cst_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module cst_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta; // first stage, read only by the second stage
  logic [W-1:0] q;

  // two flops per bit; reset value is all ones, whatever the caller ties to rst_val_i
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d_i;
      q <= meta;
    end
  end

  // rst_val_i has no effect: it is ORed with its own inverse, so q_o is q
  assign q_o = q & (rst_val_i | ~rst_val_i);

endmodule : cst_sync
`default_nettype wire

// ### testbench/cst_conv_ctrl_sva.sv
// port assertions for the conversion start and busy block
`timescale 1ns/1ns
`default_nettype none
module cst_conv_ctrl_sva
  import cst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic conversion_start_n_i,
  input wire logic cs_n_i,
  input wire logic [DATA_W-1:0] data_in_i,
  input wire logic [DATA_W-1:0] sample_result_i,
  input wire logic [DATA_W-1:0] data_out_o,
  input wire logic data_oe_n_o,
  input wire logic busy_o,
  input wire logic hold_o,
  input wire logic result_valid_o,
  input wire logic [DATA_W-1:0] write_word_o,
  input wire logic write_strobe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_busy_rise: assert property ($fell(conversion_start_n_i) && !busy_o |-> ##[2:5] busy_o)
    else $error("busy late");
  a_busy_cause: assert property ($rose(busy_o) |-> !$past(conversion_start_n_i, 2))
    else $error("busy without start");
  a_hold_busy: assert property ($rose(busy_o) |-> hold_o)
    else $error("no hold");
  a_busy_min: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("busy short");
  a_end_pulse: assert property ($fell(busy_o) |-> result_valid_o ##1 !result_valid_o)
    else $error("bad end pulse");
  a_result_load: assert property (result_valid_o |=> data_out_o == $past(sample_result_i))
    else $error("result not loaded");
  a_cs_release: assert property (cs_n_i [*6] |-> data_oe_n_o)
    else $error("bus driven");
  a_cs_nowrite: assert property (cs_n_i [*6] |-> !write_strobe_o)
    else $error("write while idle");
  a_wr_capture: assert property (write_strobe_o |-> write_word_o == $past(data_in_i, 3))
    else $error("bad write word");
  c_conv: cover property ($fell(busy_o));
  c_write: cover property (write_strobe_o);
  c_read: cover property (!data_oe_n_o);
endmodule : cst_conv_ctrl_sva
bind cst_conv_ctrl cst_conv_ctrl_sva chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .conversion_start_n_i(conversion_start_n_i), .cs_n_i(cs_n_i), .data_in_i(data_in_i),
  .sample_result_i(sample_result_i), .data_out_o(data_out_o), .data_oe_n_o(data_oe_n_o),
  .busy_o(busy_o), .hold_o(hold_o), .result_valid_o(result_valid_o),
  .write_word_o(write_word_o), .write_strobe_o(write_strobe_o));
`default_nettype wire

// ### testbench/cst_conv_ctrl_test.sv
// testbench for the conversion start and busy block
`timescale 1ns/1ns
`default_nettype none
module cst_conv_ctrl_test;
  import cst_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [DATA_W-1:0] res = 12'h5A3; // core result, changed once by t_early
  logic st_n, cclk, cs_n, rd_n, wr_n, oe_n, busy, hold, val, wstb;
  logic [DATA_W-1:0] din, dout, wword;
  wire logic [DATA_W-1:0] bus;
  logic [CNT_W-1:0] cnt;
  int failures = 0;
  int n_checks = 0;
  int n_wr = 0;
  int n_val = 0;
  // the block wins the bus only while enabled
  assign bus = (oe_n === 1'b0) ? dout : din;
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    n_wr += int'(wstb === 1'b1);
    n_val += int'(val === 1'b1);
  end
  cst_host_model host_u (.clk_i(clk), .oe_n_i(oe_n), .bus_i(bus), .start_n_o(st_n),
    .cclk_o(cclk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(din));
  cst_conv_ctrl dut_u (.clk_i(clk), .reset_n_i(rst_n), .conversion_start_n_i(st_n),
    .conv_clk_i(cclk), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_in_i(bus),
    .data_out_o(dout), .data_oe_n_o(oe_n), .sample_result_i(res), .busy_o(busy),
    .hold_o(hold), .result_valid_o(val), .write_word_o(wword), .write_strobe_o(wstb),
    .edge_count_o(cnt));
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  // strobes with select high must do nothing; low must capture
  task automatic t_rw();
    logic oe;
    logic [DATA_W-1:0] q;
    int w0;
    host_u.read(1'b1, oe, q);
    check(oe === 1'b1, "bus driven");
    w0 = n_wr;
    host_u.write(1'b1, 12'hC3A);
    check(n_wr == w0, "write taken");
    host_u.write(1'b0, 12'h9E5);
    check(n_wr == w0 + 1 && wword === 12'h9E5, "write lost");
  endtask : t_rw
  // full conversion with a refused start while busy, then read back
  task automatic t_conv();
    logic oe;
    logic [DATA_W-1:0] q;
    int v0;
    v0 = n_val;
    host_u.start_conv();
    host_u.run_clk(CONV_EDGES - 1);
    check(busy === 1'b1 && hold === 1'b1 && cnt === 4'hD, "early end");
    host_u.start_conv();
    host_u.run_clk(1);
    repeat (4) @(posedge clk);
    check(busy === 1'b0 && n_val == v0 + 1, "no end");
    host_u.read(1'b0, oe, q);
    check(oe === 1'b0 && q === res, "bad read");
    host_u.run_clk(2);
    check(busy === 1'b0, "start taken");
  endtask : t_conv
  // start caught with a clock rise takes that rise as edge one; new result read
  task automatic t_early();
    logic oe;
    logic [DATA_W-1:0] q;
    int v0;
    v0 = n_val;
    res <= 12'h3C6;
    host_u.start_with_rise();
    host_u.run_clk(CONV_EDGES - 2);
    check(busy === 1'b1 && cnt === 4'hD, "late first edge");
    host_u.run_clk(1);
    repeat (4) @(posedge clk);
    check(busy === 1'b0 && n_val == v0 + 1, "no early end");
    host_u.read(1'b0, oe, q);
    check(oe === 1'b0 && q === 12'h3C6, "stale result");
  endtask : t_early
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_rw();
    t_conv();
    t_early();
    stop_test();
  end
endmodule : cst_conv_ctrl_test
`default_nettype wire

// ### testbench/cst_host_model.sv
// host model driving the converter port pins
`timescale 1ns/1ns
`default_nettype none
module cst_host_model
  import cst_pkg::*;
(
  // clock and bus seen back
  input wire logic clk_i,
  input wire logic oe_n_i,
  input wire logic [DATA_W-1:0] bus_i,
  // pins driven
  output logic start_n_o,
  output logic cclk_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [DATA_W-1:0] data_o
);
  initial begin
    {start_n_o, cs_n_o, rd_n_o, wr_n_o, cclk_o} = 5'h1E;
    data_o = 12'h000;
  end
  // start falls while the conversion clock is low, far from its edges
  task automatic start_conv();
    @(posedge clk_i) start_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    start_n_o <= 1'b1;
  endtask : start_conv
  // start fall and clock rise land in one sampling slot: stands for a start
  // that fell a little ahead of that rise
  task automatic start_with_rise();
    @(posedge clk_i) start_n_o <= 1'b0;
    cclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    start_n_o <= 1'b1;
    cclk_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : start_with_rise
  // clock only runs in bursts and stands low in between
  task automatic run_clk(input int n);
    repeat (n) begin
      @(posedge clk_i) cclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      cclk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : run_clk
  // read: strobe held until the bus is taken at an edge
  task automatic read(input logic cs, output logic oe, output logic [DATA_W-1:0] q);
    @(posedge clk_i) cs_n_o <= cs;
    @(posedge clk_i) rd_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    oe = oe_n_i;
    q = bus_i;
    rd_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
  endtask : read
  // write: word stays well past the strobe rise, then shows its inverse
  task automatic write(input logic cs, input logic [DATA_W-1:0] w);
    @(posedge clk_i) cs_n_o <= cs;
    data_o <= w;
    wr_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    data_o <= ~w;
    cs_n_o <= 1'b1;
  endtask : write
endmodule : cst_host_model
`default_nettype wire
